// File: logic/pdotc_top.sv
// PDO transfer control: object dictionary records, node state and PDO cycle timing.
//
// Function
// R1 - Type 254 sends at set cycle in 0.1 ms; zero follows sampling rate.
// R2 - Actual cycle reads real period in microseconds while TPDO1 is type 254, else zero.
// R3 - State write: 0 pre-operational, 1 operational, 2 toggles; this node only.
// R4 - State read returns 0 for pre-operational, 1 for operational.
// R5 - Power-up selection: 0 starts pre-operational, 1 starts operational; reset reloads it to 0 here, so the node always starts pre-operational.
// R6 - Power-up operational only when selection and transfer enable both equal 1.
// R7 - Two receive comm records, entry count defaults to 2, read-write.
// R8 - Two receive mapping records of 32-bit entries, count defaults to 2.
// R9 - Two transmit comm records, entry count defaults to 2, writable.
// R10 - Two transmit mapping records of 32-bit entries, count defaults to 2.
// R11 - No PDO transmitted while transfer enable is 0.
`timescale 1ns/1ps
`default_nettype none

module pdotc_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Object dictionary access.
  input wire pdotc_pkg::pdotc_od_req_t odReq,
  output var pdotc_pkg::pdotc_od_rsp_t odRsp,
  // Sampling strobe from the measurement path.
  input wire logic sampleTick,
  // PDO transmit request stream.
  output var pdotc_pkg::pdotc_tx_t txOut,
  input wire logic txReady,
  // Node status.
  output var logic nodeOperational
);
  import pdotc_pkg::*;

  pdotc_state_t s_ff;
  pdotc_state_t nxt_s;
  logic nodeOperational_ff;
  logic nxt_nodeOperational;

  logic isComm;
  logic isMap;
  logic [1:0] rec;
  logic [1:0] ent;
  logic subOk;
  logic [1:0] mfrMask;
  logic gate;
  logic tick;
  logic [1:0] fireMask;
  logic [7:0] wByte;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rsp = '0;
    isComm = 1'b0;
    isMap = 1'b0;
    rec = REC_RX1;
    ent = 2'(odReq.sub - SUB_FIRST);
    subOk = (odReq.sub >= SUB_FIRST) && (odReq.sub <= SUB_LAST);
    wByte = odReq.wdata[7:0];
    tick = 1'b0;
    fireMask = 2'b00;

    // The node leaves boot in the first cycle after reset. The power-up choice
    // is applied once, and later state writes take over from there.
    // R5 power-up state
    // R6 enable qualifies start
    if (s_ff.node == PDOTC_BOOT) begin
      if ((s_ff.powerupSel == FLAG_ON) && (s_ff.enable == FLAG_ON)) begin
        nxt_s.node = PDOTC_OP;
      end else begin
        nxt_s.node = PDOTC_PREOP;
      end
    end

    mfrMask[0] = s_ff.commEnt[REC_TX1][ENT_TX_TYPE][7:0] == TX_TYPE_MFR_ASYNC;
    mfrMask[1] = s_ff.commEnt[REC_TX2][ENT_TX_TYPE][7:0] == TX_TYPE_MFR_ASYNC;
    // R11 enable gates sending
    gate = (s_ff.node == PDOTC_OP) && (s_ff.enable == FLAG_ON);

    // The prescaler restarts whenever sending is inhibited, so the first timed
    // request after enabling comes one full cycle later, never a short one.
    // R1 cycle timer
    if (s_ff.cycleSet == CYCLE_RST) begin
      tick = sampleTick;
      nxt_s.tenthPre = '0;
      nxt_s.unitCnt = '0;
    end else if (s_ff.tenthPre == TENTH_MS_LAST) begin
      nxt_s.tenthPre = '0;
      if (s_ff.unitCnt + 32'h1 >= s_ff.cycleSet) begin
        tick = 1'b1;
        nxt_s.unitCnt = '0;
      end else begin
        nxt_s.unitCnt = s_ff.unitCnt + 32'h1;
      end
    end else begin
      nxt_s.tenthPre = s_ff.tenthPre + 12'h1;
    end
    if (!gate) begin
      nxt_s.tenthPre = '0;
      nxt_s.unitCnt = '0;
    end
    fireMask = (tick && gate) ? mfrMask : 2'b00;

    // R2 period measurement
    if (s_ff.usPre == US_LAST) begin
      nxt_s.usPre = '0;
      if (s_ff.usCnt != 32'hffff_ffff) begin
        nxt_s.usCnt = s_ff.usCnt + 32'h1;
      end
    end else begin
      nxt_s.usPre = s_ff.usPre + 6'h1;
    end
    // Capture the count including this cycle's microsecond, otherwise a
    // 100 us period would read back as 99.
    if (fireMask != 2'b00) begin
      nxt_s.cycleAct = nxt_s.usCnt;
      nxt_s.usPre = '0;
      nxt_s.usCnt = '0;
    end

    // Two-entry buffer: pop, then push pending requests when a slot is free.
    // Ticks that find both slots full merge into one pending mask: a slow receiver
    // loses repetitions of a PDO but never the fact that it was due.
    if (s_ff.buf0.valid && txReady) begin
      nxt_s.buf0 = s_ff.buf1;
      nxt_s.buf1 = '0;
    end
    nxt_s.pendMask = s_ff.pendMask | fireMask;
    if (nxt_s.pendMask != 2'b00) begin
      if (!nxt_s.buf0.valid) begin
        nxt_s.buf0.valid = 1'b1;
        nxt_s.buf0.pdoMask = nxt_s.pendMask;
        nxt_s.pendMask = 2'b00;
      end else if (!nxt_s.buf1.valid) begin
        nxt_s.buf1.valid = 1'b1;
        nxt_s.buf1.pdoMask = nxt_s.pendMask;
        nxt_s.pendMask = 2'b00;
      end
    end
    // R11 flush when inhibited
    // Inhibit drops queued requests rather than sending them late.
    if (!gate) begin
      nxt_s.pendMask = 2'b00;
      nxt_s.buf0 = '0;
      nxt_s.buf1 = '0;
    end

    // Record decode for the PDO comm and mapping objects.
    // Sub 0 of every record is its 8-bit count; subs 1 to 4 hold 32-bit entries.
    case (odReq.index)
      IDX_RX_PDO1_COMM: begin
        isComm = 1'b1;
        rec = REC_RX1;
      end
      IDX_RX_PDO2_COMM: begin
        isComm = 1'b1;
        rec = REC_RX2;
      end
      IDX_TX_PDO1_COMM: begin
        isComm = 1'b1;
        rec = REC_TX1;
      end
      IDX_TX_PDO2_COMM: begin
        isComm = 1'b1;
        rec = REC_TX2;
      end
      IDX_RX_PDO1_MAP: begin
        isMap = 1'b1;
        rec = REC_RX1;
      end
      IDX_RX_PDO2_MAP: begin
        isMap = 1'b1;
        rec = REC_RX2;
      end
      IDX_TX_PDO1_MAP: begin
        isMap = 1'b1;
        rec = REC_TX1;
      end
      IDX_TX_PDO2_MAP: begin
        isMap = 1'b1;
        rec = REC_TX2;
      end
      default: begin
        isComm = 1'b0;
        isMap = 1'b0;
      end
    endcase

    if (odReq.req) begin
      nxt_s.rsp.ack = 1'b1;
      if (isComm || isMap) begin
        // R7 receive comm records
        // R8 receive mapping records
        // R9 transmit comm records
        // R10 transmit mapping records
        if (odReq.sub == SUB_COUNT) begin
          nxt_s.rsp.rdata = {24'h0, isComm ? s_ff.commCount[rec] : s_ff.mapCount[rec]};
          if (odReq.write && isComm) begin
            nxt_s.commCount[rec] = wByte;
          end else if (odReq.write) begin
            nxt_s.mapCount[rec] = wByte;
          end
        end else if (subOk) begin
          nxt_s.rsp.rdata = isComm ? s_ff.commEnt[rec][ent] : s_ff.mapEnt[rec][ent];
          if (odReq.write && isComm) begin
            nxt_s.commEnt[rec][ent] = odReq.wdata;
          end else if (odReq.write) begin
            nxt_s.mapEnt[rec][ent] = odReq.wdata;
          end
        end else begin
          nxt_s.rsp.err = 1'b1;
        end
      end else if (odReq.sub != SUB_COUNT) begin
        nxt_s.rsp.err = 1'b1;
      end else begin
        case (odReq.index)
          IDX_CYCLE_SET: begin
            nxt_s.rsp.rdata = s_ff.cycleSet;
            if (odReq.write) begin
              nxt_s.cycleSet = odReq.wdata;
            end
          end
          IDX_CYCLE_ACT: begin
            // R2 zero unless TPDO1 is type 254
            // The measured value is read-only; a write is refused and changes nothing.
            nxt_s.rsp.rdata = mfrMask[0] ? s_ff.cycleAct : 32'h0;
            nxt_s.rsp.err = odReq.write;
          end
          IDX_STATE_CTRL: begin
            // R4 state readback
            nxt_s.rsp.rdata = {31'h0, s_ff.node == PDOTC_OP};
            if (odReq.write) begin
              // Commands are not qualified by the enable flag; it gates sending and the power-up start.
              // R3 local state change
              case (wByte)
                CMD_PREOP: nxt_s.node = PDOTC_PREOP;
                CMD_OP: nxt_s.node = PDOTC_OP;
                CMD_TOGGLE: begin
                  nxt_s.node = (s_ff.node == PDOTC_OP) ? PDOTC_PREOP : PDOTC_OP;
                end
                default: nxt_s.rsp.err = 1'b1;
              endcase
            end
          end
          IDX_POWERUP_SEL: begin
            nxt_s.rsp.rdata = {24'h0, s_ff.powerupSel};
            if (odReq.write) begin
              if (wByte == FLAG_OFF || wByte == FLAG_ON) begin
                nxt_s.powerupSel = wByte;
              end else begin
                nxt_s.rsp.err = 1'b1;
              end
            end
          end
          IDX_PDO_ENABLE: begin
            nxt_s.rsp.rdata = {24'h0, s_ff.enable};
            if (odReq.write) begin
              if (wByte == FLAG_OFF || wByte == FLAG_ON) begin
                nxt_s.enable = wByte;
              end else begin
                nxt_s.rsp.err = 1'b1;
              end
            end
          end
          default: nxt_s.rsp.err = 1'b1;
        endcase
      end
      // A refused access returns no data, so software never sees stale values.
      if (nxt_s.rsp.err) begin
        nxt_s.rsp.rdata = '0;
      end
    end

    // The status pin is registered from the next state so that it changes at the
    // same edge as the state itself, and so comes straight from a flip-flop.
    nxt_nodeOperational = nxt_s.node == PDOTC_OP;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.node <= PDOTC_BOOT;
      // R7 count default
      // R8 count default
      // R9 count default
      // R10 count default
      s_ff.commCount <= {4{COUNT_RST}};
      s_ff.mapCount <= {4{COUNT_RST}};
      s_ff.cycleSet <= CYCLE_RST;
      s_ff.powerupSel <= POWERUP_RST;
      s_ff.enable <= ENABLE_RST;
      nodeOperational_ff <= 1'b0;
    end else begin
      s_ff <= nxt_s;
      nodeOperational_ff <= nxt_nodeOperational;
    end
  end

  assign odRsp = s_ff.rsp;
  assign txOut = s_ff.buf0;
  assign nodeOperational = nodeOperational_ff;

endmodule : pdotc_top

`default_nettype wire

// File: logic/pdotc_pkg.sv
// Package with constants and types of the PDO transfer control block.
package pdotc_pkg;

  // Clock and time base.
  localparam int CLK_PERIOD_NS = 25;
  localparam int TENTH_MS_NS = 100000;
  localparam int TENTH_MS_CYC = (TENTH_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / CLK_PERIOD_NS;
  localparam logic [11:0] TENTH_MS_LAST = 12'(TENTH_MS_CYC - 1);
  localparam logic [5:0] US_LAST = 6'(US_CYC - 1);

  // Object indices.
  localparam logic [15:0] IDX_RX_PDO1_COMM = 16'h1400;
  localparam logic [15:0] IDX_RX_PDO2_COMM = 16'h1401;
  localparam logic [15:0] IDX_RX_PDO1_MAP = 16'h1600;
  localparam logic [15:0] IDX_RX_PDO2_MAP = 16'h1601;
  localparam logic [15:0] IDX_TX_PDO1_COMM = 16'h1800;
  localparam logic [15:0] IDX_TX_PDO2_COMM = 16'h1801;
  localparam logic [15:0] IDX_TX_PDO1_MAP = 16'h1a00;
  localparam logic [15:0] IDX_TX_PDO2_MAP = 16'h1a01;
  localparam logic [15:0] IDX_CYCLE_SET = 16'h3400;
  localparam logic [15:0] IDX_CYCLE_ACT = 16'h3401;
  localparam logic [15:0] IDX_STATE_CTRL = 16'h3402;
  localparam logic [15:0] IDX_POWERUP_SEL = 16'h3403;
  localparam logic [15:0] IDX_PDO_ENABLE = 16'h6f60;

  // Record numbers inside the comm and map arrays.
  localparam logic [1:0] REC_RX1 = 2'h0;
  localparam logic [1:0] REC_RX2 = 2'h1;
  localparam logic [1:0] REC_TX1 = 2'h2;
  localparam logic [1:0] REC_TX2 = 2'h3;

  // Sub-indices and field values.
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_LAST = 8'h04;
  localparam logic [1:0] ENT_TX_TYPE = 2'h1;
  localparam logic [7:0] COUNT_RST = 8'h02;
  localparam logic [7:0] TX_TYPE_MFR_ASYNC = 8'hfe;
  localparam logic [7:0] CMD_PREOP = 8'h00;
  localparam logic [7:0] CMD_OP = 8'h01;
  localparam logic [7:0] CMD_TOGGLE = 8'h02;
  localparam logic [7:0] FLAG_OFF = 8'h00;
  localparam logic [7:0] FLAG_ON = 8'h01;
  localparam logic [7:0] POWERUP_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h01;
  localparam logic [31:0] CYCLE_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    PDOTC_BOOT = 2'b00,
    PDOTC_PREOP = 2'b01,
    PDOTC_OP = 2'b10
  } pdotc_node_t;

  // Object dictionary access request and answer.
  typedef struct packed {
    logic req;
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } pdotc_od_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } pdotc_od_rsp_t;

  // One transmit request: bit 0 asks for TPDO1, bit 1 for TPDO2.
  typedef struct packed {
    logic valid;
    logic [1:0] pdoMask;
  } pdotc_tx_t;

  typedef struct packed {
    pdotc_node_t node;
    pdotc_od_rsp_t rsp;
    logic [3:0][7:0] commCount;
    logic [3:0][3:0][31:0] commEnt;
    logic [3:0][7:0] mapCount;
    logic [3:0][3:0][31:0] mapEnt;
    logic [31:0] cycleSet;
    logic [31:0] cycleAct;
    logic [7:0] powerupSel;
    logic [7:0] enable;
    logic [11:0] tenthPre;
    logic [31:0] unitCnt;
    logic [5:0] usPre;
    logic [31:0] usCnt;
    logic [1:0] pendMask;
    pdotc_tx_t buf0;
    pdotc_tx_t buf1;
  } pdotc_state_t;

endpackage : pdotc_pkg

// File: tb/pdotc_assertions.sv
// Port checker for the PDO transfer control block.
`timescale 1ns/1ps
`default_nettype none
module pdotc_assertions (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports.
  input wire pdotc_pkg::pdotc_od_req_t odReq,
  input wire pdotc_pkg::pdotc_od_rsp_t odRsp,
  input wire logic sampleTick,
  input wire pdotc_pkg::pdotc_tx_t txOut,
  input wire logic txReady,
  input wire logic nodeOperational
);
  import pdotc_pkg::*;
  logic stWr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign stWr = odReq.req && odReq.write && odReq.index == IDX_STATE_CTRL && odReq.sub == 8'h00;
  a_ack_after_req: assert property (odReq.req |=> odRsp.ack)
    else $error("answer missing");
  a_no_spare_ack: assert property (!odReq.req |=> !odRsp.ack)
    else $error("answer without request");
  a_tx_held: assert property (txOut.valid && !txReady && !odReq.req && !$past(odReq.req)
    |=> txOut.valid && $stable(txOut.pdoMask))
    else $error("request dropped while stalled");
  a_no_tx_preop: assert property (!nodeOperational [*2] |-> !txOut.valid)
    else $error("request while not operational");
  a_state_op: assert property (stWr && odReq.wdata == 32'(CMD_OP) |=> nodeOperational)
    else $error("operational command ignored");
  a_state_preop: assert property (stWr && odReq.wdata == 32'(CMD_PREOP) |=> !nodeOperational)
    else $error("pre-operational command ignored");
  a_state_toggle: assert property (stWr && odReq.wdata == 32'(CMD_TOGGLE) |=>
    nodeOperational != $past(nodeOperational))
    else $error("toggle command ignored");
  a_state_read: assert property (odReq.req && !odReq.write && odReq.sub == SUB_COUNT
    && odReq.index == IDX_STATE_CTRL |=> odRsp.rdata == {31'h0, $past(nodeOperational)})
    else $error("state read wrong");
  a_actual_ro: assert property (odReq.req && odReq.write && odReq.index == IDX_CYCLE_ACT
    |=> odRsp.ack && odRsp.err)
    else $error("write to read-only accepted");
  c_pop: cover property (txOut.valid && txReady);
  c_stall: cover property (txOut.valid && !txReady);
  c_toggle: cover property (stWr && odReq.wdata == 32'(CMD_TOGGLE));
endmodule : pdotc_assertions
bind pdotc_top pdotc_assertions u_chk (.clk(clk), .rst_n(rst_n), .odReq(odReq),
  .odRsp(odRsp), .sampleTick(sampleTick), .txOut(txOut), .txReady(txReady),
  .nodeOperational(nodeOperational));
`default_nettype wire

// File: tb/pdotc_sink.sv
// Receiver model: takes transmit requests, stalls on command and counts them.
`timescale 1ns/1ps
`default_nettype none
module pdotc_sink (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Stream.
  input wire pdotc_pkg::pdotc_tx_t txOut,
  output logic txReady,
  // Control and results.
  input wire logic stall,
  output logic [7:0] popCnt_ff,
  output logic [1:0] lastMask_ff
);
  import pdotc_pkg::*;
  assign txReady = !stall;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      popCnt_ff <= 8'h00;
      lastMask_ff <= 2'h0;
    end else if (txOut.valid && txReady) begin
      popCnt_ff <= popCnt_ff + 8'h01;
      lastMask_ff <= txOut.pdoMask;
    end
  end
endmodule : pdotc_sink
`default_nettype wire

// File: tb/tb_pdo_transfer_control.sv
// Self-checking bench for the PDO transfer control block.
`timescale 1ns/1ps
`default_nettype none
module tb_pdo_transfer_control;
  import pdotc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pdotc_od_req_t odReq = '0;
  pdotc_od_rsp_t odRsp;
  logic sampleTick = 1'b0;
  pdotc_tx_t txOut;
  logic txReady;
  logic nodeOperational;
  logic stall = 1'b0;
  logic [7:0] popCnt;
  logic [1:0] lastMask;
  logic [31:0] rd;
  int n_errors = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  pdotc_top uut (.clk(clk), .rst_n(rst_n), .odReq(odReq), .odRsp(odRsp),
    .sampleTick(sampleTick), .txOut(txOut), .txReady(txReady),
    .nodeOperational(nodeOperational));
  pdotc_sink sink (.clk(clk), .rst_n(rst_n), .txOut(txOut), .txReady(txReady),
    .stall(stall), .popCnt_ff(popCnt), .lastMask_ff(lastMask));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sb,
      input logic [31:0] wd, input logic expErr);
    @(negedge clk);
    odReq = '{1'b1, wr, idx, sb, wd};
    // The answer stands for one cycle only, so it is taken at the edge that drops req.
    @(negedge clk);
    odReq.req = 1'b0;
    chk({31'h0, odRsp.ack}, 32'h1);
    chk({31'h0, odRsp.err}, {31'h0, expErr});
    rd = odRsp.rdata;
  endtask : od
  task automatic tick;
    @(negedge clk);
    sampleTick = 1'b1;
    @(negedge clk);
    sampleTick = 1'b0;
  endtask : tick
  task automatic waitPops(input logic [7:0] n, input int lim);
    for (int i = 0; i < lim && popCnt !== n; i++) @(negedge clk);
    if (popCnt !== n) begin
      chk({24'h0, popCnt}, {24'h0, n});
      end_sim();
    end
  endtask : waitPops
  task automatic tRegs;
    logic [15:0] idx[8] = '{IDX_RX_PDO1_COMM, IDX_RX_PDO2_COMM, IDX_RX_PDO1_MAP,
      IDX_RX_PDO2_MAP, IDX_TX_PDO1_COMM, IDX_TX_PDO2_COMM, IDX_TX_PDO1_MAP, IDX_TX_PDO2_MAP};
    for (int i = 0; i < 8; i++) begin
      od(1'b1, idx[i], 8'h00, 32'h3, 1'b0);
      chk(rd, 32'h2);
      od(1'b0, idx[i], 8'h00, 32'h0, 1'b0);
      chk(rd, 32'h3);
      od(1'b1, idx[i], 8'h01, 32'h1234_5600 + 32'(i), 1'b0);
      od(1'b0, idx[i], 8'h01, 32'h0, 1'b0);
      chk(rd, 32'h1234_5600 + 32'(i));
    end
    od(1'b0, 16'h2000, 8'h00, 32'h0, 1'b1);
    od(1'b1, IDX_CYCLE_ACT, 8'h00, 32'h5, 1'b1);
  endtask : tRegs
  task automatic tState;
    logic [7:0] cmd[4] = '{CMD_OP, CMD_TOGGLE, CMD_TOGGLE, CMD_PREOP};
    chk({31'h0, nodeOperational}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      od(1'b1, IDX_STATE_CTRL, 8'h00, 32'(cmd[i]), 1'b0);
      od(1'b0, IDX_STATE_CTRL, 8'h00, 32'h0, 1'b0);
      chk(rd, {31'h0, ~i[0]});
      chk({31'h0, nodeOperational}, {31'h0, ~i[0]});
    end
    od(1'b1, IDX_STATE_CTRL, 8'h00, 32'h3, 1'b1);
    od(1'b1, IDX_POWERUP_SEL, 8'h00, 32'h2, 1'b1);
  endtask : tState
  task automatic tStream;
    od(1'b1, IDX_TX_PDO1_COMM, 8'h02, 32'hfe, 1'b0);
    od(1'b1, IDX_STATE_CTRL, 8'h00, 32'h1, 1'b0);
    tick();
    waitPops(8'h01, 20);
    chk({30'h0, lastMask}, 32'h1);
    stall = 1'b1;
    repeat (4) tick();
    repeat (5) @(negedge clk);
    chk({31'h0, txOut.valid}, 32'h1);
    stall = 1'b0;
    waitPops(8'h04, 20);
    repeat (20) @(negedge clk);
    chk({24'h0, popCnt}, 32'h4);
    od(1'b1, IDX_PDO_ENABLE, 8'h00, 32'h0, 1'b0);
    tick();
    repeat (5) @(negedge clk);
    chk({24'h0, popCnt}, 32'h4);
    od(1'b1, IDX_PDO_ENABLE, 8'h00, 32'h1, 1'b0);
    od(1'b1, IDX_TX_PDO2_COMM, 8'h02, 32'hfe, 1'b0);
    tick();
    waitPops(8'h05, 20);
    chk({30'h0, lastMask}, 32'h3);
    od(1'b1, IDX_CYCLE_SET, 8'h00, 32'h1, 1'b0);
    waitPops(8'h07, 9000);
    od(1'b0, IDX_CYCLE_ACT, 8'h00, 32'h0, 1'b0);
    chk(rd, 32'h64);
    od(1'b1, IDX_TX_PDO1_COMM, 8'h02, 32'h0, 1'b0);
    od(1'b0, IDX_CYCLE_ACT, 8'h00, 32'h0, 1'b0);
    chk(rd, 32'h0);
  endtask : tStream
  task automatic tReset;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk({31'h0, nodeOperational}, 32'h0);
    od(1'b0, IDX_TX_PDO1_COMM, 8'h00, 32'h0, 1'b0);
    chk(rd, 32'h2);
    od(1'b0, IDX_CYCLE_SET, 8'h00, 32'h0, 1'b0);
    chk(rd, 32'h0);
  endtask : tReset
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    tRegs();
    tState();
    tStream();
    tReset();
    end_sim();
  end
endmodule : tb_pdo_transfer_control
`default_nettype wire
